/* inc/srd_pkg.sv */
package srd_pkg;

	// clock and timebase
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// timer counters count timebase ticks, not clock cycles
	localparam int TW = 20;

	// register offsets
	localparam logic [7:0] REG_RESET_DOG = 8'h8c;
	localparam logic [7:0] REG_DLY_RESET = 8'h8d;
	localparam logic [7:0] REG_GEN_OUT = 8'h98;
	localparam logic [7:0] REG_IRQ_CLEAR = 8'h99;

	// field positions
	localparam int F_HOLD_LSB = 0;
	localparam int F_SDOG_LSB = 2;
	localparam int F_LDOG_LSB = 5;
	localparam int F_SKEW_LSB = 0;
	localparam int GEN_OUT_BITS = 4;

	// reset values
	localparam logic [7:0] RST_RESET_DOG = 8'h00;
	localparam logic [7:0] RST_DLY_RESET = 8'h00;
	localparam logic [3:0] RST_GEN_OUT = 4'h0;

	// base periods in ticks (one tick is one millisecond)
	localparam logic [TW-1:0] HOLD_BASE = 20'h0_0019;
	localparam logic [TW-1:0] SDOG_BASE = 20'h0_0064;
	localparam logic [TW-1:0] LDOG_BASE = 20'h0_03e8;
	localparam logic [TW-1:0] SKEW_BASE = 20'h0_000a;

	// doubling period table: base times two to the power sel
	function automatic logic [TW-1:0] srd_scale(input logic [TW-1:0] base,
		input logic [2:0] sel);
		srd_scale = base << sel;
	endfunction

endpackage

/* inc/srd_dog_if.sv */
`timescale 1ns/1ps
interface srd_dog_if;
	logic tick;
	logic kick;
	logic run;
	logic [srd_pkg::TW-1:0] limit;
	logic expired;
	modport ctl (output tick, output kick, output run, output limit, input expired);
	modport dog (input tick, input kick, input run, input limit, output expired);
endinterface

/* rtl/srd_timebase.sv */
`timescale 1ns/1ps
module srd_timebase import srd_pkg::*; #(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input wire logic clock,
	input wire logic srst,
	output logic tick
);
	logic [31:0] cnt;

	// free-running prescaler, one-cycle tick per period
	always_ff @(posedge clock) begin
		if (srst) begin
			cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (cnt >= 32'(TICK_CYCLES_P - 1)) begin
			cnt <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 32'h0000_0001;
			tick <= 1'b0;
		end
	end
endmodule

/* rtl/srd_dog.sv */
`timescale 1ns/1ps
module srd_dog import srd_pkg::*; (
	input wire logic clock,
	input wire logic srst,
	srd_dog_if.dog d
);
	logic [TW-1:0] cnt;

	// counts ticks while running; a kick or a stop restarts it
	always_ff @(posedge clock) begin
		if (srst || !d.run || d.kick) begin
			cnt <= '0;
			d.expired <= 1'b0;
		end else if (d.tick && !d.expired) begin
			if (cnt + 20'h0_0001 >= d.limit) begin
				d.expired <= 1'b1;
			end else begin
				cnt <= cnt + 20'h0_0001;
			end
		end
	end
endmodule

/* rtl/srd_supervisor.sv */
`timescale 1ns/1ps
// How it works
// R01: manual reset low pulls system reset low on the next clock, no timer wait.
// R02: manual reset is unmaskable; pulse equals its low time plus hold time.
// R03: both dog timers run only while the dog enable input is low.
// R04: a rising kick edge restarts both dog timers; host must kick in time.
// R05: short dog timeout shows before long dog timeout unless the short dog is idle.
// R06: each dog has its own period field; field value zero idles it.
// R07: short dog output pulls low once its period is exceeded.
// R08: long dog output pulls low once its period is exceeded.
// R09: system reset low on undervolt or manual reset, held after last cause.
// R10: any over-current sense flag also drives system reset low.
// R11: delayed reset follows system reset conditions once power-up is finished.
// R12: at power-up a skew timeout starts on first supply; asserts if late.
// R13: undervolt override high suppresses all undervolt reset causes.
// R14: alert pin pulls low while any scanned input exceeds its limits.
// R15: limit interrupt pulls low when a selected scanned input exceeds limits.
// R16: overvolt, overcurrent and fault interrupts pull low on selected conditions.
// R17: interrupts latch; clear strobe or interrupt clear register access clears.
// R18: trouble output polarity selects out-of-limit or in-limit indication.
// R19: good-state output has the same two selectable polarities.
// R20: converter idle output low only while no conversion runs.
// R21: general output bit one pulls its pin low; all bits reset cleared.
// R22: auto scan enable must be high for scanning; low disables scan results.
// R23: open-drain pins are pull-down enables: zero pulls low, one releases.
// R24: hold and skew times count ticks of a free-running timebase.
module srd_supervisor import srd_pkg::*; #(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic manual_reset_n,
	input wire logic [3:0] supply_present,
	input wire logic [3:0] supply_below,
	input wire logic [3:0] current_sense_inputs,
	input wire logic undervolt_reset_override,
	input wire logic dog_timers_enable_n,
	input wire logic dog_kick_in,
	input wire logic auto_scan_enable,
	input wire logic [3:0] limit_exceed,
	input wire logic [3:0] limit_select,
	input wire logic [3:0] overvolt_cond,
	input wire logic [3:0] overvolt_select,
	input wire logic [3:0] overcurrent_select,
	input wire logic [3:0] fault_cond,
	input wire logic [3:0] fault_select,
	input wire logic irq_clear_n,
	input wire logic [7:0] out_of_limit,
	input wire logic [7:0] trouble_select,
	input wire logic trouble_in_limit_mode,
	input wire logic [7:0] good_select,
	input wire logic good_in_limit_mode,
	input wire logic conversion_busy,
	output logic system_reset_n,
	output logic delayed_reset_n,
	output logic short_dog_timeout_n,
	output logic long_dog_timeout_n,
	output logic smbus_alert_n,
	output logic limit_irq_n,
	output logic overvoltage_irq_n,
	output logic overcurrent_irq_n,
	output logic trouble_irq_n,
	output logic trouble_out_n,
	output logic good_state_out_n,
	output logic converter_idle_n,
	output logic [3:0] general_outputs
);

	// configuration registers
	logic [7:0] reset_and_dog_timer_config;
	logic [7:0] delayed_reset_timeout_config;
	logic [3:0] general_output_control;

	// timebase and dog timers
	logic tick;
	logic kick_prev;
	logic kick_edge;
	srd_dog_if short_if();
	srd_dog_if long_if();

	// reset sequencing state
	logic uv_cause;
	logic oc_cause;
	logic any_cause;
	logic [TW-1:0] hold_cnt;
	logic [TW-1:0] skew_cnt;
	logic skew_running;
	logic all_good;

	typedef enum logic [1:0] {
		SRD_PU_WAIT,
		SRD_PU_SKEW,
		SRD_PU_DONE
	} srd_pu_t;
	srd_pu_t pu_state;
	srd_pu_t next_pu_state;

	// interrupt latches
	logic irq_clear;
	logic limit_hit;
	logic ov_hit;
	logic oc_hit;
	logic fault_hit;
	logic limit_latch;
	logic ov_latch;
	logic oc_latch;
	logic fault_latch;

	// trouble and good-state sources
	logic trouble_out_hit;
	logic good_out_hit;

	// period fields and their decoded lengths
	logic [1:0] hold_sel;
	logic [2:0] sdog_sel;
	logic [2:0] ldog_sel;
	logic [2:0] skew_sel;
	assign hold_sel = reset_and_dog_timer_config[F_HOLD_LSB +: 2];
	assign sdog_sel = reset_and_dog_timer_config[F_SDOG_LSB +: 3];
	assign ldog_sel = reset_and_dog_timer_config[F_LDOG_LSB +: 3];
	assign skew_sel = delayed_reset_timeout_config[F_SKEW_LSB +: 3];

	srd_timebase #(
		.TICK_CYCLES_P(TICK_CYCLES_P)
	) u_timebase (
		.clock(clock),
		.srst(srst),
		.tick(tick)
	);

	// register writes; widths beyond the general outputs are dropped
	always_ff @(posedge clock) begin
		if (srst) begin
			reset_and_dog_timer_config <= RST_RESET_DOG;
			delayed_reset_timeout_config <= RST_DLY_RESET;
			general_output_control <= RST_GEN_OUT; // R21
		end else if (reg_wr) begin
			unique case (reg_addr)
				REG_RESET_DOG: begin
					reset_and_dog_timer_config <= reg_wdata;
				end
				REG_DLY_RESET: begin
					delayed_reset_timeout_config <= reg_wdata;
				end
				REG_GEN_OUT: begin
					general_output_control <= reg_wdata[GEN_OUT_BITS-1:0]; // R21
				end
				default: begin
				end
			endcase
		end
	end

	// read data; interrupt clear register shows the latched interrupts
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_RESET_DOG: reg_rdata <= reset_and_dog_timer_config;
				REG_DLY_RESET: reg_rdata <= delayed_reset_timeout_config;
				REG_GEN_OUT: reg_rdata <= {4'h0, general_output_control};
				REG_IRQ_CLEAR: reg_rdata <= {4'h0, fault_latch, oc_latch, ov_latch, limit_latch};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// kick edge detect; input is already synchronous
	always_ff @(posedge clock) begin
		if (srst) begin
			kick_prev <= 1'b0;
		end else begin
			kick_prev <= dog_kick_in;
		end
	end
	assign kick_edge = dog_kick_in && !kick_prev; // R04

	// both dogs share tick, kick and the enable pin; zero period idles one
	assign short_if.tick = tick;
	assign short_if.kick = kick_edge; // R04
	assign short_if.run = !dog_timers_enable_n && (sdog_sel != 3'h0); // R03 R06
	assign short_if.limit = srd_scale(SDOG_BASE, sdog_sel - 3'h1); // R06
	assign long_if.tick = tick;
	assign long_if.kick = kick_edge; // R04
	assign long_if.run = !dog_timers_enable_n && (ldog_sel != 3'h0); // R03 R06
	assign long_if.limit = srd_scale(LDOG_BASE, ldog_sel - 3'h1); // R06

	srd_dog u_short_dog (
		.clock(clock),
		.srst(srst),
		.d(short_if)
	);

	srd_dog u_long_dog (
		.clock(clock),
		.srst(srst),
		.d(long_if)
	);

	// long output waits for the short one unless short is idle, so the
	// order holds even if software programs the long period shorter
	always_ff @(posedge clock) begin
		if (srst) begin
			short_dog_timeout_n <= 1'b1;
			long_dog_timeout_n <= 1'b1;
		end else begin
			short_dog_timeout_n <= !short_if.expired; // R07 R23
			long_dog_timeout_n <= !(long_if.expired &&
				(short_if.expired || !short_if.run)); // R05 R08 R23
		end
	end

	// reset causes
	assign uv_cause = |supply_below && !undervolt_reset_override; // R09 R13
	assign oc_cause = |current_sense_inputs; // R10
	assign any_cause = uv_cause || oc_cause || !manual_reset_n; // R01 R02 R09

	// hold counter reloads while any cause stands, counts ticks after
	always_ff @(posedge clock) begin
		if (srst) begin
			hold_cnt <= '0;
		end else if (any_cause) begin
			hold_cnt <= srd_scale(HOLD_BASE, {1'b0, hold_sel}); // R02 R09
		end else if (tick && hold_cnt != '0) begin
			hold_cnt <= hold_cnt - 20'h0_0001; // R24
		end
	end

	// system reset: immediate on any cause, released when hold runs out
	always_ff @(posedge clock) begin
		if (srst) begin
			system_reset_n <= 1'b0;
		end else begin
			system_reset_n <= !(any_cause || hold_cnt != '0); // R01 R02 R09 R10
		end
	end

	// power-up skew supervision for the delayed reset
	assign all_good = !(|supply_below) || undervolt_reset_override; // R13
	assign skew_running = (pu_state == SRD_PU_SKEW);

	always_comb begin
		next_pu_state = pu_state;
		unique case (pu_state)
			SRD_PU_WAIT: begin
				if (|supply_present) begin
					next_pu_state = SRD_PU_SKEW; // R12
				end
			end
			SRD_PU_SKEW: begin
				if (all_good || skew_cnt == '0) begin
					next_pu_state = SRD_PU_DONE; // R12
				end
			end
			SRD_PU_DONE: begin
				next_pu_state = SRD_PU_DONE;
			end
			default: begin
				next_pu_state = SRD_PU_WAIT;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			pu_state <= SRD_PU_WAIT;
		end else begin
			pu_state <= next_pu_state;
		end
	end

	// skew counter loads when the first supply appears
	always_ff @(posedge clock) begin
		if (srst) begin
			skew_cnt <= '0;
		end else if (pu_state == SRD_PU_WAIT) begin
			skew_cnt <= srd_scale(SKEW_BASE, skew_sel); // R12
		end else if (skew_running && tick && skew_cnt != '0) begin
			skew_cnt <= skew_cnt - 20'h0_0001; // R24
		end
	end

	// delayed reset stays released during skew, then tracks system reset
	always_ff @(posedge clock) begin
		if (srst) begin
			delayed_reset_n <= 1'b1;
		end else if (pu_state != SRD_PU_DONE) begin
			delayed_reset_n <= !(skew_running && skew_cnt == '0 && !all_good); // R12
		end else begin
			delayed_reset_n <= !(any_cause || hold_cnt != '0); // R11
		end
	end

	// scan results only count while the outside holds scanning on
	assign limit_hit = auto_scan_enable && |(limit_exceed & limit_select); // R15 R22
	assign ov_hit = |(overvolt_cond & overvolt_select); // R16
	assign oc_hit = |(current_sense_inputs & overcurrent_select); // R16
	assign fault_hit = |(fault_cond & fault_select); // R16

	// any access to the clear register clears, as does the strobe
	assign irq_clear = !irq_clear_n ||
		((reg_wr || reg_rd) && reg_addr == REG_IRQ_CLEAR); // R17

	// latches: a new event in the clear cycle wins over the clear
	always_ff @(posedge clock) begin
		if (srst) begin
			limit_latch <= 1'b0;
			ov_latch <= 1'b0;
			oc_latch <= 1'b0;
			fault_latch <= 1'b0;
		end else begin
			limit_latch <= limit_hit || (limit_latch && !irq_clear); // R15 R17
			ov_latch <= ov_hit || (ov_latch && !irq_clear); // R16 R17
			oc_latch <= oc_hit || (oc_latch && !irq_clear); // R16 R17
			fault_latch <= fault_hit || (fault_latch && !irq_clear); // R16 R17
		end
	end

	// interrupt pins follow the latches one cycle later
	always_ff @(posedge clock) begin
		if (srst) begin
			limit_irq_n <= 1'b1;
			overvoltage_irq_n <= 1'b1;
			overcurrent_irq_n <= 1'b1;
			trouble_irq_n <= 1'b1;
		end else begin
			limit_irq_n <= !limit_latch; // R23
			overvoltage_irq_n <= !ov_latch; // R23
			overcurrent_irq_n <= !oc_latch; // R23
			trouble_irq_n <= !fault_latch; // R23
		end
	end

	// alert is a level, not latched, and is gated by the scan enable
	always_ff @(posedge clock) begin
		if (srst) begin
			smbus_alert_n <= 1'b1;
		end else begin
			smbus_alert_n <= !(auto_scan_enable && |limit_exceed); // R14 R22
		end
	end

	// programmable-polarity trouble and good-state pins
	assign trouble_out_hit = |(out_of_limit & trouble_select);
	assign good_out_hit = |(out_of_limit & good_select);

	always_ff @(posedge clock) begin
		if (srst) begin
			trouble_out_n <= 1'b1;
			good_state_out_n <= 1'b1;
		end else begin
			trouble_out_n <= trouble_in_limit_mode ? trouble_out_hit : !trouble_out_hit; // R18
			good_state_out_n <= good_in_limit_mode ? good_out_hit : !good_out_hit; // R19
		end
	end

	// converter status and general outputs
	always_ff @(posedge clock) begin
		if (srst) begin
			converter_idle_n <= 1'b1;
			general_outputs <= 4'hf;
		end else begin
			converter_idle_n <= conversion_busy; // R20
			general_outputs <= ~general_output_control; // R21 R23
		end
	end

endmodule

/* verif/srd_supervisor_assertions.sv */
`timescale 1ns/1ps
module srd_checker import srd_pkg::*; (
	input wire logic clock,
	input wire logic srst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic manual_reset_n,
	input wire logic [3:0] supply_below,
	input wire logic [3:0] current_sense_inputs,
	input wire logic undervolt_reset_override,
	input wire logic dog_timers_enable_n,
	input wire logic dog_kick_in,
	input wire logic irq_clear_n,
	input wire logic conversion_busy,
	input wire logic system_reset_n,
	input wire logic short_dog_timeout_n,
	input wire logic long_dog_timeout_n,
	input wire logic limit_irq_n,
	input wire logic converter_idle_n,
	input wire logic [3:0] general_outputs
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	logic sdog_idle;
	wire acc = (reg_wr || reg_rd) && reg_addr == REG_IRQ_CLEAR;
	// short dog idle flag: an idle short dog lets the long one fire alone
	always_ff @(posedge clock) begin
		if (srst)
			sdog_idle <= 1'h1;
		else if (reg_wr && reg_addr == REG_RESET_DOG)
			sdog_idle <= reg_wdata[F_SDOG_LSB +: 3] == 3'h0;
	end
	AST_MR: assert property (!manual_reset_n |-> ##[1:2] !system_reset_n)
		else $error("manual reset not followed");
	AST_OC: assert property (|current_sense_inputs |-> ##[1:2] !system_reset_n)
		else $error("over-current reset missing");
	AST_UV: assert property ((|supply_below && !undervolt_reset_override)
		|-> ##[1:2] !system_reset_n)
		else $error("undervolt reset missing");
	AST_DOG_OFF: assert property ($fell(short_dog_timeout_n)
		|-> !$past(dog_timers_enable_n, 2))
		else $error("short dog fired while disabled");
	AST_ORDER: assert property ($fell(long_dog_timeout_n)
		|-> (!short_dog_timeout_n || sdog_idle))
		else $error("long dog before short dog");
	AST_KICK: assert property ($rose(dog_kick_in)
		|-> ##[1:3] (short_dog_timeout_n && long_dog_timeout_n))
		else $error("kick did not clear dogs");
	AST_IRQ: assert property ((!limit_irq_n && irq_clear_n && $past(irq_clear_n)
		&& !acc && !$past(acc)) |=> !limit_irq_n)
		else $error("limit irq not latched");
	AST_GPO: assert property ((reg_wr && reg_addr == REG_GEN_OUT)
		##1 !(reg_wr && reg_addr == REG_GEN_OUT)
		|=> general_outputs == ~$past(reg_wdata[3:0], 2))
		else $error("general outputs mismatch");
	AST_IDLE: assert property (conversion_busy ##1 conversion_busy |-> converter_idle_n)
		else $error("idle shown during conversion");
	COV_LONG: cover property ($fell(long_dog_timeout_n));
	COV_RST: cover property ($rose(system_reset_n));
	COV_LIM: cover property ($fell(limit_irq_n));
	COV_IDLE: cover property ($fell(long_dog_timeout_n) && sdog_idle);
endmodule
bind srd_supervisor srd_checker i_chk (.clock, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
	.manual_reset_n, .supply_below, .current_sense_inputs, .undervolt_reset_override,
	.dog_timers_enable_n, .dog_kick_in, .irq_clear_n, .conversion_busy, .system_reset_n,
	.short_dog_timeout_n, .long_dog_timeout_n, .limit_irq_n, .converter_idle_n, .general_outputs);

/* verif/srd_host_model.sv */
`timescale 1ns/1ps
module srd_host_model #(
	parameter int GAP = 200
) (
	input wire logic clock,
	input wire logic kick_on,
	input wire logic scan_on,
	output logic dog_kick_in,
	output logic auto_scan_enable
);
	int cnt = 0;
	logic armed = 1'h0;
	logic kick_q = 1'h0;
	assign auto_scan_enable = scan_on;
	assign dog_kick_in = kick_q;
	// enable taken on the rising edge so a falling-edge bench write cannot race it
	always @(posedge clock) begin
		armed <= kick_on;
	end
	// one-cycle kick every gap, well inside the short period
	always @(negedge clock) begin
		cnt <= (armed && cnt < GAP - 1) ? cnt + 1 : 0;
		kick_q <= armed && cnt == GAP - 1;
	end
endmodule

/* verif/tb_supervisor_reset_dog_irq.sv */
`timescale 1ns/1ps
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tb_supervisor_reset_dog_irq;
	import srd_pkg::*;
	logic clock = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic manual_reset_n = 1'h1, undervolt_reset_override = 1'h0, dog_timers_enable_n = 1'h1;
	logic [3:0] supply_present = 4'h1, supply_below = 4'he, current_sense_inputs = 4'h0;
	logic [3:0] limit_exceed = 4'h0, limit_select = 4'h0, overvolt_cond = 4'h0;
	logic [3:0] overvolt_select = 4'h0, overcurrent_select = 4'h0;
	logic [3:0] fault_cond = 4'h0, fault_select = 4'h0;
	logic irq_clear_n = 1'h1, trouble_in_limit_mode = 1'h0, good_in_limit_mode = 1'h0;
	logic [7:0] out_of_limit = 8'h00, trouble_select = 8'h00, good_select = 8'h00;
	logic conversion_busy = 1'h0, kick_on = 1'h0, scan_on = 1'h0;
	logic dog_kick_in, auto_scan_enable, system_reset_n, delayed_reset_n;
	logic short_dog_timeout_n, long_dog_timeout_n, smbus_alert_n, limit_irq_n;
	logic overvoltage_irq_n, overcurrent_irq_n, trouble_irq_n, trouble_out_n;
	logic good_state_out_n, converter_idle_n;
	logic [3:0] general_outputs;
	int bad_count = 0;
	int check_count = 0;
	// short tick keeps the long dog inside a few thousand cycles
	always #12.5 clock = ~clock;
	srd_host_model #(.GAP(200)) i_host (.clock, .kick_on, .scan_on, .dog_kick_in,
		.auto_scan_enable);
	srd_supervisor #(.TICK_CYCLES_P(4)) i_dut (.clock, .srst, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .manual_reset_n, .supply_present, .supply_below,
		.current_sense_inputs, .undervolt_reset_override, .dog_timers_enable_n, .dog_kick_in,
		.auto_scan_enable, .limit_exceed, .limit_select, .overvolt_cond, .overvolt_select,
		.overcurrent_select, .fault_cond, .fault_select, .irq_clear_n, .out_of_limit,
		.trouble_select, .trouble_in_limit_mode, .good_select, .good_in_limit_mode,
		.conversion_busy, .system_reset_n, .delayed_reset_n, .short_dog_timeout_n,
		.long_dog_timeout_n, .smbus_alert_n, .limit_irq_n, .overvoltage_irq_n,
		.overcurrent_irq_n, .trouble_irq_n, .trouble_out_n, .good_state_out_n,
		.converter_idle_n, .general_outputs);
	task automatic test_done();
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		cyc(1);
		reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd = 1'h1;
		reg_addr = a;
		cyc(1);
		reg_rd = 1'h0;
		cyc(1);
		`CK("rdata", e, reg_rdata)
	endtask
	task automatic clr();
		irq_clear_n = 1'h0;
		cyc(1);
		irq_clear_n = 1'h1;
		cyc(3);
	endtask
	// one supply up, others late: skew window then delayed reset
	task automatic t_power();
		cyc(20);
		`CK("dly", 1'h1, delayed_reset_n)
		cyc(50);
		`CK("dly", 1'h0, delayed_reset_n)
		supply_present = 4'hf;
		supply_below = 4'h0;
		cyc(130);
		`CK("sys", 1'h1, system_reset_n)
		`CK("dly", 1'h1, delayed_reset_n)
	endtask
	task automatic t_regs();
		rd(REG_RESET_DOG, 8'h00);
		rd(REG_DLY_RESET, 8'h00);
		`CK("gpo", 4'hf, general_outputs)
		wr(REG_GEN_OUT, 8'ha5);
		rd(REG_GEN_OUT, 8'h05);
		`CK("gpo", 4'ha, general_outputs)
		wr(8'h10, 8'hff);
		rd(8'h10, 8'h00);
		wr(REG_GEN_OUT, 8'h00);
	endtask
	// pulse length is low time plus hold of 100 cycles
	task automatic t_mr();
		manual_reset_n = 1'h0;
		cyc(2);
		`CK("sys", 1'h0, system_reset_n)
		`CK("dly", 1'h0, delayed_reset_n)
		cyc(18);
		manual_reset_n = 1'h1;
		cyc(85);
		`CK("sys", 1'h0, system_reset_n)
		cyc(30);
		`CK("sys", 1'h1, system_reset_n)
	endtask
	// hold select one doubles the hold to 200 cycles
	task automatic t_oc();
		wr(REG_RESET_DOG, 8'h01);
		current_sense_inputs = 4'h4;
		cyc(2);
		`CK("sys", 1'h0, system_reset_n)
		current_sense_inputs = 4'h0;
		cyc(150);
		`CK("sys", 1'h0, system_reset_n)
		cyc(70);
		`CK("sys", 1'h1, system_reset_n)
		undervolt_reset_override = 1'h1;
		supply_below = 4'h2;
		cyc(4);
		`CK("sys", 1'h1, system_reset_n)
		supply_below = 4'h0;
		undervolt_reset_override = 1'h0;
	endtask
	// short 400 cycles, long 4000 cycles from the last kick
	task automatic t_dog();
		wr(REG_RESET_DOG, 8'h24);
		cyc(500);
		`CK("sdog", 1'h1, short_dog_timeout_n)
		dog_timers_enable_n = 1'h0;
		kick_on = 1'h1;
		cyc(1200);
		`CK("sdog", 1'h1, short_dog_timeout_n)
		kick_on = 1'h0;
		cyc(440);
		`CK("sdog", 1'h0, short_dog_timeout_n)
		`CK("ldog", 1'h1, long_dog_timeout_n)
		cyc(3600);
		`CK("ldog", 1'h0, long_dog_timeout_n)
		kick_on = 1'h1;
		cyc(205);
		kick_on = 1'h0;
		cyc(3);
		`CK("sdog", 1'h1, short_dog_timeout_n)
		`CK("ldog", 1'h1, long_dog_timeout_n)
		dog_timers_enable_n = 1'h1;
	endtask
	// short dog idle: long fires alone after 4000 cycles, short never pulls
	task automatic t_idle();
		wr(REG_RESET_DOG, 8'h20);
		dog_timers_enable_n = 1'h0;
		cyc(4040);
		`CK("sdog", 1'h1, short_dog_timeout_n)
		`CK("ldog", 1'h0, long_dog_timeout_n)
		dog_timers_enable_n = 1'h1;
		cyc(3);
		`CK("ldog", 1'h1, long_dog_timeout_n)
	endtask
	task automatic t_irq();
		scan_on = 1'h1;
		limit_select = 4'h1;
		limit_exceed = 4'h1;
		cyc(3);
		`CK("lim", 1'h0, limit_irq_n)
		`CK("alert", 1'h0, smbus_alert_n)
		limit_exceed = 4'h0;
		cyc(3);
		`CK("lim", 1'h0, limit_irq_n)
		`CK("alert", 1'h1, smbus_alert_n)
		clr();
		`CK("lim", 1'h1, limit_irq_n)
		scan_on = 1'h0;
		limit_exceed = 4'h1;
		cyc(3);
		`CK("lim", 1'h1, limit_irq_n)
		limit_exceed = 4'h0;
		overvolt_select = 4'h1;
		overvolt_cond = 4'h1;
		cyc(3);
		`CK("ov", 1'h0, overvoltage_irq_n)
		overvolt_cond = 4'h0;
		rd(REG_IRQ_CLEAR, 8'h02);
		cyc(2);
		`CK("ov", 1'h1, overvoltage_irq_n)
		fault_select = 4'h2;
		fault_cond = 4'h2;
		cyc(3);
		`CK("flt", 1'h0, trouble_irq_n)
		fault_cond = 4'h0;
		wr(REG_IRQ_CLEAR, 8'h00);
		cyc(3);
		`CK("flt", 1'h1, trouble_irq_n)
		overcurrent_select = 4'h8;
		current_sense_inputs = 4'h8;
		cyc(3);
		`CK("oc", 1'h0, overcurrent_irq_n)
		current_sense_inputs = 4'h0;
		clr();
		`CK("oc", 1'h1, overcurrent_irq_n)
	endtask
	// both polarities against both source states
	task automatic t_out();
		trouble_select = 8'h01;
		good_select = 8'h01;
		for (int m = 0; m < 2; m++) begin
			for (int o = 0; o < 2; o++) begin
				trouble_in_limit_mode = m[0];
				good_in_limit_mode = m[0];
				out_of_limit = {7'h00, o[0]};
				conversion_busy = o[0];
				cyc(3);
				`CK("trb", ~(m[0] ^ o[0]), trouble_out_n)
				`CK("good", ~(m[0] ^ o[0]), good_state_out_n)
				`CK("idle", o[0], converter_idle_n)
			end
		end
	endtask
	// mid-run reset with no supply, then a doubled skew window of 80 cycles
	task automatic t_skew();
		wr(REG_GEN_OUT, 8'h03);
		cyc(1);
		`CK("gpo", 4'hc, general_outputs)
		srst = 1'h1;
		supply_present = 4'h0;
		supply_below = 4'hf;
		cyc(2);
		`CK("sys", 1'h0, system_reset_n)
		srst = 1'h0;
		cyc(1);
		`CK("dly", 1'h1, delayed_reset_n)
		`CK("gpo", 4'hf, general_outputs)
		rd(REG_RESET_DOG, 8'h00);
		wr(REG_DLY_RESET, 8'h01);
		cyc(10);
		`CK("dly", 1'h1, delayed_reset_n)
		supply_present = 4'h2;
		cyc(70);
		`CK("dly", 1'h1, delayed_reset_n)
		cyc(20);
		`CK("dly", 1'h0, delayed_reset_n)
		supply_present = 4'hf;
		supply_below = 4'h0;
		cyc(110);
		`CK("sys", 1'h1, system_reset_n)
		`CK("dly", 1'h1, delayed_reset_n)
	endtask
	initial begin
		cyc(5);
		srst = 1'h0;
		t_power();
		t_regs();
		t_mr();
		t_oc();
		t_dog();
		t_idle();
		t_irq();
		t_out();
		t_skew();
		test_done();
	end
	// run needs about 11000 cycles
	initial begin
		#(25 * 40000);
		bad_count++;
		test_done();
	end
endmodule
